//--- hdl/st_gctl_pkg.sv
// constants for the s/t global control register bank
// assumes a 250 MHz system clock and an AXI4-Lite master
package st_gctl_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W  = 8;

  // printed offsets are word indices; byte address is four times
  localparam logic [5:0] IDX_ST_GLOBAL_CONTROL = 6'h02;
  localparam logic [5:0] IDX_AUX_CONTROL       = 6'h10;
  localparam logic [5:0] IDX_STATUS            = 6'h11;

  // st_global_control fields
  localparam int unsigned TIMING_RECOVERY_SELECT   = 0;
  localparam int unsigned ST_POWERDOWN_CONTROL     = 1;
  localparam int unsigned ST_SOFT_RESET            = 2;
  localparam int unsigned ECHO_CHANNEL_CONTROL     = 3;
  localparam int unsigned NONTRANSPARENT_LOOP_CTRL = 4;
  localparam int unsigned TDM_BUS_SELECT           = 5;
  localparam int unsigned LOOP_ACT_MODE_SELECT     = 6;
  localparam int unsigned ST_ONLY_ACTIVATION       = 7;

  // aux_control fields
  localparam int unsigned TRANSPARENCY_BIT     = 0;
  localparam int unsigned POWER_STATUS_TWO_BIT = 1;
  localparam int unsigned POWER_STATUS_ONE_BIT = 2;

  // status fields
  localparam int unsigned STS_ACTIVATION = 0;
  localparam int unsigned STS_UP_FORCED  = 1;
  localparam int unsigned STS_ST_RESET   = 2;
  localparam int unsigned STS_ST_LOWPWR  = 3;

  localparam logic [REG_W-1:0] CTRL_RESET = 8'hFF;
  localparam logic [REG_W-1:0] AUX_RESET  = 8'h07;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_RESP = 2'b01
  } wr_state_e;
endpackage

//--- hdl/st_loop_path.sv
// 2B+D loopback, all-ones forcing and e channel echo datapath
// assumes one serial bit per clock on each stream
`timescale 1ns/1ps
`default_nettype none
module st_loop_path
  import st_gctl_pkg::*;
(
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  input  wire logic i_loop_en,
  input  wire logic i_echo_en,
  input  wire logic i_st_run,
  input  wire logic i_act_rx,
  input  wire logic i_transparency_bit_en,
  input  wire logic i_u_rx_bd,
  input  wire logic i_st_rx_bd,
  input  wire logic i_st_rx_d,
  output logic      o_u_tx_bd,
  output logic      o_st_tx_bd,
  output logic      o_e_bit,
  output logic      o_up_forced
);
  logic rel_reg;
  logic rel_next;
  logic released;
  logic forced;

  // release latches once activation or transparency arrives
  assign released = rel_reg | i_act_rx | i_transparency_bit_en;
  assign forced   = i_loop_en & ~released;
  assign rel_next = i_loop_en & released;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rel_reg     <= 1'b0;
      o_u_tx_bd   <= 1'b1;
      o_st_tx_bd  <= 1'b1;
      o_e_bit     <= 1'b0;
      o_up_forced <= 1'b0;
    end else begin
      rel_reg <= rel_next;
      // u receive looped to u transmit with loop on; s/t receive to u transmit with loop off
      o_u_tx_bd   <= i_loop_en ? (forced | i_u_rx_bd) : i_st_rx_bd;
      o_st_tx_bd  <= i_loop_en | i_u_rx_bd;
      o_e_bit     <= i_echo_en & i_st_run & i_st_rx_d;
      o_up_forced <= forced;
    end
  end
endmodule
`default_nettype wire

//--- hdl/st_global_control.sv
// s/t global control register bank with AXI4-Lite slave
// assumes synchronous inputs and a single-beat AXI4-Lite master
`timescale 1ns/1ps
`default_nettype none
module st_global_control
  import st_gctl_pkg::*;
(
  input  wire logic              i_sys_clk,
  input  wire logic              i_nrst,
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] i_awaddr,
  input  wire logic              i_awvalid,
  output logic                   o_awready,
  input  wire logic [DATA_W-1:0] i_wdata,
  input  wire logic [3:0]        i_wstrb,
  input  wire logic              i_wvalid,
  output logic                   o_wready,
  output logic [1:0]             o_bresp,
  output logic                   o_bvalid,
  input  wire logic              i_bready,
  input  wire logic [ADDR_W-1:0] i_araddr,
  input  wire logic              i_arvalid,
  output logic                   o_arready,
  output logic [DATA_W-1:0]      o_rdata,
  output logic [1:0]             o_rresp,
  output logic                   o_rvalid,
  input  wire logic              i_rready,
  // device side
  input  wire logic              i_act_mode_interrupt_pin,
  input  wire logic              i_received_activation_bit,
  input  wire logic              i_u_rx_bd,
  input  wire logic              i_st_rx_bd,
  input  wire logic              i_st_rx_d,
  output logic                   o_u_tx_bd,
  output logic                   o_st_tx_bd,
  output logic                   o_e_bit,
  output logic                   o_st_reset_n,
  output logic                   o_st_lowpower,
  output logic                   o_act_detect_en,
  output logic                   o_transparency_en,
  output logic                   o_st_only_activation_n,
  output logic                   o_loop_act_mode,
  output logic                   o_adaptive_timing,
  output logic                   o_power_status_one,
  output logic                   o_power_status_two,
  output logic                   o_tdm_mode,
  // shared pins
  input  wire logic              i_frame_sync_pin,
  output logic                   o_frame_sync_pin,
  output logic                   o_frame_sync_pin_oe,
  input  wire logic              i_tdm_data_in_pin,
  input  wire logic              i_tdm_data_out_pin,
  output logic                   o_tdm_data_out_pin,
  output logic                   o_tdm_data_out_pin_oe,
  input  wire logic              i_tdm_clock_pin,
  // tdm engine and sync side
  input  wire logic              i_tdm_tx_data,
  input  wire logic              i_sync_loop_ind,
  output logic                   o_frame_sync,
  output logic                   o_tdm_rx_data,
  output logic                   o_tdm_clock
);
  logic [REG_W-1:0]  ctrl_reg;
  logic [REG_W-1:0]  ctrl_next;
  logic [REG_W-1:0]  aux_reg;
  logic [REG_W-1:0]  aux_next;
  logic              armed_reg;
  logic              aw_hold_reg;
  logic              w_hold_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [DATA_W-1:0] wdata_reg;
  logic [3:0]        wstrb_reg;
  wr_state_e         wr_state_reg;

  // write channel decode
  logic              aw_take;
  logic              w_take;
  logic              aw_have;
  logic              w_have;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  logic [3:0]        wr_strb;
  logic              wr_fire;
  logic [5:0]        wr_idx;
  logic              wr_ctrl;
  logic              wr_aux;
  logic              wr_ok;
  logic              lane0;

  assign aw_take = i_awvalid & o_awready;
  assign w_take  = i_wvalid & o_wready;
  assign aw_have = aw_hold_reg | aw_take;
  assign w_have  = w_hold_reg | w_take;
  assign wr_addr = aw_hold_reg ? awaddr_reg : i_awaddr;
  assign wr_data = w_hold_reg ? wdata_reg : i_wdata;
  assign wr_strb = w_hold_reg ? wstrb_reg : i_wstrb;
  assign wr_fire = (wr_state_reg == TX_IDLE) & aw_have & w_have;
  assign wr_idx  = wr_addr[ADDR_W-1:2];
  assign wr_ok   = (wr_addr[1:0] == 2'h0) & ((wr_idx == IDX_ST_GLOBAL_CONTROL)
                 | (wr_idx == IDX_AUX_CONTROL) | (wr_idx == IDX_STATUS));
  assign lane0   = wr_strb[0];
  assign wr_ctrl = wr_fire & lane0 & (wr_addr[1:0] == 2'h0)
                 & (wr_idx == IDX_ST_GLOBAL_CONTROL);
  assign wr_aux  = wr_fire & lane0 & (wr_addr[1:0] == 2'h0)
                 & (wr_idx == IDX_AUX_CONTROL);

  // register next values
  // stored bits read back as written
  assign ctrl_next = wr_ctrl ? wr_data[REG_W-1:0] : ctrl_reg;
  assign aux_next  = wr_aux ? wr_data[REG_W-1:0] : aux_reg;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_reg  <= CTRL_RESET;
      aux_reg   <= AUX_RESET;
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
      ctrl_reg  <= ctrl_next;
      // strap bit 6 at reset release
      if (!armed_reg) begin
        ctrl_reg[LOOP_ACT_MODE_SELECT] <= i_act_mode_interrupt_pin;
      end
      aux_reg <= aux_next;
    end
  end

  // write address/data capture, taken in either order
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_hold_reg  <= 1'b0;
      w_hold_reg   <= 1'b0;
      awaddr_reg   <= '0;
      wdata_reg    <= '0;
      wstrb_reg    <= 4'h0;
      o_awready    <= 1'b0;
      o_wready     <= 1'b0;
      o_bvalid     <= 1'b0;
      o_bresp      <= RESP_OKAY;
      wr_state_reg <= TX_IDLE;
    end else begin
      if (aw_take) begin
        awaddr_reg <= i_awaddr;
      end
      if (w_take) begin
        wdata_reg <= i_wdata;
        wstrb_reg <= i_wstrb;
      end
      case (wr_state_reg)
        TX_IDLE: begin
          if (wr_fire) begin
            aw_hold_reg  <= 1'b0;
            w_hold_reg   <= 1'b0;
            o_awready    <= 1'b0;
            o_wready     <= 1'b0;
            o_bvalid     <= 1'b1;
            o_bresp      <= wr_ok ? RESP_OKAY : RESP_SLVERR;
            wr_state_reg <= TX_RESP;
          end else begin
            aw_hold_reg <= aw_have;
            w_hold_reg  <= w_have;
            o_awready   <= ~aw_have;
            o_wready    <= ~w_have;
          end
        end
        TX_RESP: begin
          if (i_bready) begin
            o_bvalid     <= 1'b0;
            o_awready    <= 1'b1;
            o_wready     <= 1'b1;
            wr_state_reg <= TX_IDLE;
          end
        end
        default: begin
          o_bvalid     <= 1'b0;
          wr_state_reg <= TX_IDLE;
        end
      endcase
    end
  end

  // read channel
  logic [5:0]        rd_idx;
  logic              rd_ok;
  logic              ar_take;
  logic [REG_W-1:0]  status_word;
  logic [REG_W-1:0]  rd_byte;
  logic              up_forced;

  assign ar_take = i_arvalid & o_arready;
  assign rd_idx  = i_araddr[ADDR_W-1:2];
  assign rd_ok   = (i_araddr[1:0] == 2'h0) & ((rd_idx == IDX_ST_GLOBAL_CONTROL)
                 | (rd_idx == IDX_AUX_CONTROL) | (rd_idx == IDX_STATUS));
  assign status_word = {4'h0, o_st_lowpower, ~o_st_reset_n, up_forced,
                        i_received_activation_bit};
  assign rd_byte = (rd_idx == IDX_ST_GLOBAL_CONTROL) ? ctrl_reg
                 : (rd_idx == IDX_AUX_CONTROL) ? aux_reg
                 : (rd_idx == IDX_STATUS) ? status_word : 8'h00;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= RESP_OKAY;
    end else if (ar_take) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_ok ? {24'h000000, rd_byte} : '0;
      o_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (o_rvalid) begin
      if (i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end else begin
      o_arready <= 1'b1;
    end
  end

  // control decode
  logic tdm_on;
  logic st_run;
  logic loop_en;

  assign tdm_on  = ~ctrl_reg[TDM_BUS_SELECT];
  assign st_run  = ctrl_reg[ST_SOFT_RESET];
  assign loop_en = ~ctrl_reg[NONTRANSPARENT_LOOP_CTRL];

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_st_reset_n           <= 1'b0;
      o_st_lowpower          <= 1'b0;
      o_act_detect_en        <= 1'b1;
      o_transparency_en      <= 1'b0;
      o_st_only_activation_n <= 1'b1;
      o_loop_act_mode        <= 1'b0;
      o_adaptive_timing      <= 1'b1;
      o_power_status_one     <= 1'b1;
      o_power_status_two     <= 1'b1;
      o_tdm_mode             <= 1'b0;
    end else begin
      // soft reset mirrors the reset pin
      o_st_reset_n           <= st_run;
      o_st_lowpower          <= ~ctrl_reg[ST_POWERDOWN_CONTROL];
      o_act_detect_en        <= 1'b1;
      o_transparency_en      <= ~aux_reg[TRANSPARENCY_BIT];
      o_st_only_activation_n <= ctrl_reg[ST_ONLY_ACTIVATION];
      o_loop_act_mode        <= ctrl_reg[LOOP_ACT_MODE_SELECT];
      o_tdm_mode             <= tdm_on;
      // timing bit only counts in tdm mode
      o_adaptive_timing  <= tdm_on ? ctrl_reg[TIMING_RECOVERY_SELECT] : i_tdm_data_in_pin;
      o_power_status_two <= tdm_on ? aux_reg[POWER_STATUS_TWO_BIT] : i_tdm_data_out_pin;
      o_power_status_one <= tdm_on ? aux_reg[POWER_STATUS_ONE_BIT] : i_tdm_clock_pin;
    end
  end

  // shared pin mux; pins reset as inputs so nothing fights the board
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_frame_sync_pin      <= 1'b0;
      o_frame_sync_pin_oe   <= 1'b0;
      o_tdm_data_out_pin    <= 1'b0;
      o_tdm_data_out_pin_oe <= 1'b0;
      o_frame_sync          <= 1'b0;
      o_tdm_rx_data         <= 1'b0;
      o_tdm_clock           <= 1'b0;
    end else begin
      // tdm and standalone roles on the shared pins
      o_frame_sync_pin      <= tdm_on ? 1'b0 : i_sync_loop_ind;
      o_frame_sync_pin_oe   <= ~tdm_on;
      o_tdm_data_out_pin    <= tdm_on ? i_tdm_tx_data : 1'b0;
      o_tdm_data_out_pin_oe <= tdm_on;
      o_frame_sync          <= tdm_on & i_frame_sync_pin;
      o_tdm_rx_data         <= tdm_on & i_tdm_data_in_pin;
      o_tdm_clock           <= tdm_on & i_tdm_clock_pin;
    end
  end

  // host clears echo bit in loops
  st_loop_path u_loop (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_loop_en   (loop_en),
    .i_echo_en   (ctrl_reg[ECHO_CHANNEL_CONTROL]),
    .i_st_run    (st_run),
    .i_act_rx    (i_received_activation_bit),
    .i_transparency_bit_en   (~aux_reg[TRANSPARENCY_BIT]),
    .i_u_rx_bd   (i_u_rx_bd),
    .i_st_rx_bd  (i_st_rx_bd),
    .i_st_rx_d   (i_st_rx_d),
    .o_u_tx_bd   (o_u_tx_bd),
    .o_st_tx_bd  (o_st_tx_bd),
    .o_e_bit     (o_e_bit),
    .o_up_forced (up_forced)
  );
endmodule
`default_nettype wire

//--- testbench/st_global_control_assertions.sv
// port-level checks for the s/t global control bank
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module st_global_control_assertions
  import st_gctl_pkg::*;
(
  input wire logic              i_sys_clk,
  input wire logic              i_nrst,
  input wire logic              i_bready,
  input wire logic              o_bvalid,
  input wire logic [1:0]        o_bresp,
  input wire logic              o_rvalid,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic              i_u_rx_bd,
  input wire logic              i_st_rx_bd,
  input wire logic              i_st_rx_d,
  input wire logic              o_u_tx_bd,
  input wire logic              o_st_tx_bd,
  input wire logic              o_e_bit,
  input wire logic              o_act_detect_en,
  input wire logic              o_adaptive_timing,
  input wire logic              o_power_status_two,
  input wire logic              o_tdm_mode,
  input wire logic              i_tdm_data_in_pin,
  input wire logic              i_tdm_data_out_pin,
  input wire logic              o_tdm_rx_data,
  input wire logic              o_frame_sync,
  input wire logic              o_tdm_clock,
  input wire logic              o_frame_sync_pin_oe,
  input wire logic              o_tdm_data_out_pin_oe
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  // outputs of the first edge after reset still carry reset values
  sequence s_settled;
    $past(i_nrst);
  endsequence
  sequence s_wr_wait;
    o_bvalid && !i_bready;
  endsequence

  chk_bresp_hold: assert property (s_wr_wait |=> o_bvalid && $stable(o_bresp))
    else $error("write response dropped before accept");
  chk_rdata_upper: assert property (o_rvalid |-> o_rdata[DATA_W-1:REG_W] == '0)
    else $error("read data upper bits not zero");
  chk_echo_source: assert property (o_e_bit |-> $past(i_st_rx_d))
    else $error("e channel one without received d bit");
  chk_st_tx_source: assert property (!o_st_tx_bd |-> !$past(i_u_rx_bd))
    else $error("terminal data zero without u receive zero");
  chk_loop_off_path: assert property (!o_st_tx_bd |-> o_u_tx_bd == $past(i_st_rx_bd))
    else $error("u transmit not from s/t receive with loop off");
  chk_act_detect_on: assert property (o_act_detect_en)
    else $error("activation detector powered down");
  chk_timing_pin_role: assert property (s_settled ##0 !o_tdm_mode |->
      o_adaptive_timing == $past(i_tdm_data_in_pin))
    else $error("standalone timing mode not from pin");
  chk_ps2_pin_role: assert property (s_settled ##0 !o_tdm_mode |->
      o_power_status_two == $past(i_tdm_data_out_pin))
    else $error("standalone power status two not from pin");
  chk_tdm_rx_route: assert property (o_tdm_mode |-> o_tdm_rx_data == $past(i_tdm_data_in_pin))
    else $error("tdm data in not routed");
  chk_standalone_quiet: assert property (!o_tdm_mode |-> !(o_tdm_rx_data || o_frame_sync ||
      o_tdm_clock))
    else $error("tdm outputs active in standalone");
  chk_oe_exclusive: assert property (!(o_frame_sync_pin_oe && o_tdm_data_out_pin_oe))
    else $error("both shared pin drivers enabled");
endmodule
`default_nettype wire

//--- testbench/st_host_model.sv
// host processor model: single-beat AXI4-Lite master
// assumes the slave samples on the rising edge; waits are bounded
`timescale 1ns/1ps
`default_nettype none
module st_host_model
  import st_gctl_pkg::*;
(
  input  wire logic              i_sys_clk,
  output logic [ADDR_W-1:0]      o_awaddr,
  output logic                   o_awvalid,
  input  wire logic              i_awready,
  output logic [DATA_W-1:0]      o_wdata,
  output logic [3:0]             o_wstrb,
  output logic                   o_wvalid,
  input  wire logic              i_wready,
  input  wire logic [1:0]        i_bresp,
  input  wire logic              i_bvalid,
  output logic                   o_bready,
  output logic [ADDR_W-1:0]      o_araddr,
  output logic                   o_arvalid,
  input  wire logic              i_arready,
  input  wire logic [DATA_W-1:0] i_rdata,
  input  wire logic [1:0]        i_rresp,
  input  wire logic              i_rvalid,
  output logic                   o_rready
);
  // timeout leaves response 3, which no expectation accepts
  localparam int LIMIT = 64;
  initial begin
    o_awaddr  = '0;
    o_awvalid = 1'h0;
    o_wdata   = '0;
    o_wstrb   = 4'h0;
    o_wvalid  = 1'h0;
    o_bready  = 1'h0;
    o_araddr  = '0;
    o_arvalid = 1'h0;
    o_rready  = 1'h0;
  end
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d,
                    output logic [1:0] r);
    bit aw;
    bit wd;
    aw = 1'h1;
    wd = 1'h1;
    r  = 2'h3;
    @(posedge i_sys_clk);
    o_awaddr  <= a;
    o_wdata   <= DATA_W'(d);
    o_wstrb   <= 4'hF;
    o_awvalid <= 1'h1;
    o_wvalid  <= 1'h1;
    o_bready  <= 1'h1;
    for (int n = 0; n < LIMIT; n++) begin
      @(posedge i_sys_clk);
      if (!aw && !wd && i_bvalid) begin
        r = i_bresp;
        o_bready <= 1'h0;
        break;
      end
      if (aw && i_awready) begin
        aw = 1'h0;
        o_awvalid <= 1'h0;
      end
      if (wd && i_wready) begin
        wd = 1'h0;
        o_wvalid <= 1'h0;
      end
    end
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                    output logic [1:0] r);
    bit ar;
    ar = 1'h1;
    d  = '0;
    r  = 2'h3;
    @(posedge i_sys_clk);
    o_araddr  <= a;
    o_arvalid <= 1'h1;
    o_rready  <= 1'h1;
    for (int n = 0; n < LIMIT; n++) begin
      @(posedge i_sys_clk);
      if (!ar && i_rvalid) begin
        d = i_rdata;
        r = i_rresp;
        o_rready <= 1'h0;
        break;
      end
      if (ar && i_arready) begin
        ar = 1'h0;
        o_arvalid <= 1'h0;
      end
    end
  endtask
endmodule
`default_nettype wire

//--- testbench/st_global_control_tb_top.sv
// self-checking bench for the s/t global control bank
// assumes the host model owns the register bus; other inputs driven here
`timescale 1ns/1ps
`default_nettype none
module st_global_control_tb_top
  import st_gctl_pkg::*;
;
  localparam logic [ADDR_W-1:0] A_CTRL = {IDX_ST_GLOBAL_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] A_AUX  = {IDX_AUX_CONTROL, 2'h0};
  localparam logic [ADDR_W-1:0] A_STS  = {IDX_STATUS, 2'h0};
  logic [ADDR_W-1:0] i_awaddr, i_araddr;
  logic [DATA_W-1:0] i_wdata, o_rdata;
  logic [3:0]        i_wstrb;
  logic [1:0]        o_bresp, o_rresp;
  logic i_sys_clk, i_nrst, i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready;
  logic i_arvalid, o_arready, o_rvalid, i_rready, i_act_mode_interrupt_pin;
  logic i_received_activation_bit, i_u_rx_bd, i_st_rx_bd, i_st_rx_d, o_u_tx_bd;
  logic o_st_tx_bd, o_e_bit, o_st_reset_n, o_st_lowpower, o_act_detect_en;
  logic o_transparency_en, o_st_only_activation_n, o_loop_act_mode, o_adaptive_timing;
  logic o_power_status_one, o_power_status_two, o_tdm_mode, o_frame_sync_pin;
  logic o_frame_sync_pin_oe, i_tdm_data_in_pin, o_tdm_data_out_pin, o_tdm_data_out_pin_oe;
  logic i_tdm_clock_pin, i_tdm_tx_data, i_sync_loop_ind, o_frame_sync, o_tdm_rx_data;
  logic o_tdm_clock, fs_drv, p8_drv;
  wire logic i_frame_sync_pin, i_tdm_data_out_pin;
  int fail_count = 0;
  int cmp_count  = 0;
  // shared pins resolve from whichever side has its driver on
  assign i_frame_sync_pin   = o_frame_sync_pin_oe ? o_frame_sync_pin : fs_drv;
  assign i_tdm_data_out_pin = o_tdm_data_out_pin_oe ? o_tdm_data_out_pin : p8_drv;
  always #2 i_sys_clk = ~i_sys_clk;
  st_global_control u_dut (.*);
  st_host_model u_host (
    .i_sys_clk (i_sys_clk),
    .o_awaddr  (i_awaddr),
    .o_awvalid (i_awvalid),
    .i_awready (o_awready),
    .o_wdata   (i_wdata),
    .o_wstrb   (i_wstrb),
    .o_wvalid  (i_wvalid),
    .i_wready  (o_wready),
    .i_bresp   (o_bresp),
    .i_bvalid  (o_bvalid),
    .o_bready  (i_bready),
    .o_araddr  (i_araddr),
    .o_arvalid (i_arvalid),
    .i_arready (o_arready),
    .i_rdata   (o_rdata),
    .i_rresp   (o_rresp),
    .i_rvalid  (o_rvalid),
    .o_rready  (i_rready)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task automatic ck(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %0h seen %0h", nm, e, g);
    end
  endtask
  task automatic w(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d, input logic [1:0] e);
    logic [1:0] r;
    u_host.wr(a, d, r);
    ck("bresp", e, r);
    tick(2);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input logic [1:0] er);
    logic [DATA_W-1:0] d;
    logic [1:0]        r;
    u_host.rd(a, d, r);
    ck("rresp", er, r);
    ck("rdata", e, d);
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic t_reset(input logic strap);
    i_nrst                   <= 1'h0;
    i_act_mode_interrupt_pin <= strap;
    tick(3);
    ck("st_reset_n", 1'h0, o_st_reset_n);
    i_nrst <= 1'h1;
    tick(3);
    i_act_mode_interrupt_pin <= ~strap;
    rd(A_CTRL, {24'h0, 1'h1, strap, 6'h3F}, RESP_OKAY);
    rd(A_AUX, DATA_W'(AUX_RESET), RESP_OKAY);
    ck("loop_act_mode", strap, o_loop_act_mode);
    ck("st_reset_n", 1'h1, o_st_reset_n);
    ck("st_lowpower", 1'h0, o_st_lowpower);
    ck("st_only_activation_n", 1'h1, o_st_only_activation_n);
  endtask
  task automatic t_bits();
    w(A_CTRL, 8'hFD, RESP_OKAY);
    ck("st_lowpower", 1'h1, o_st_lowpower);
    ck("act_detect_en", 1'h1, o_act_detect_en);
    i_st_rx_d <= 1'h1;
    w(A_CTRL, 8'hFB, RESP_OKAY);
    ck("st_reset_n", 1'h0, o_st_reset_n);
    ck("e_bit", 1'h0, o_e_bit);
    rd(8'h0C, 32'h0, RESP_SLVERR);
    w(8'h0C, 8'h00, RESP_SLVERR);
    w(A_STS, 8'h00, RESP_OKAY);
    rd(A_CTRL, 32'hFB, RESP_OKAY);
    rd(A_STS, 32'h04, RESP_OKAY);
    w(A_CTRL, 8'hFF, RESP_OKAY);
    ck("e_bit", 1'h1, o_e_bit);
    w(A_CTRL, 8'hF7, RESP_OKAY);
    ck("e_bit", 1'h0, o_e_bit);
  endtask
  task automatic t_loop();
    i_u_rx_bd                 <= 1'h0;
    i_st_rx_bd                <= 1'h0;
    i_received_activation_bit <= 1'h0;
    w(A_CTRL, 8'hE7, RESP_OKAY);
    ck("u_tx_bd", 1'h1, o_u_tx_bd);
    ck("st_tx_bd", 1'h1, o_st_tx_bd);
    rd(A_STS, 32'h02, RESP_OKAY);
    i_received_activation_bit <= 1'h1;
    tick(3);
    ck("u_tx_bd", 1'h0, o_u_tx_bd);
    i_received_activation_bit <= 1'h0;
    w(A_CTRL, 8'hF7, RESP_OKAY);
    w(A_AUX, 8'h06, RESP_OKAY);
    ck("transparency_en", 1'h1, o_transparency_en);
    w(A_CTRL, 8'hE7, RESP_OKAY);
    tick(1);
    ck("u_tx_bd", 1'h0, o_u_tx_bd);
    w(A_AUX, AUX_RESET, RESP_OKAY);
    w(A_CTRL, 8'hFF, RESP_OKAY);
  endtask
  task automatic t_tdm();
    p8_drv          <= 1'h0;
    i_tdm_clock_pin <= 1'h0;
    tick(2);
    ck("adaptive_timing", 1'h0, o_adaptive_timing);
    ck("power_status_two", 1'h0, o_power_status_two);
    ck("power_status_one", 1'h0, o_power_status_one);
    ck("fs_pin", 1'h1, o_frame_sync_pin & o_frame_sync_pin_oe);
    w(A_CTRL, 8'hDF, RESP_OKAY);
    ck("tdm_mode", 1'h1, o_tdm_mode);
    ck("adaptive_timing", 1'h1, o_adaptive_timing);
    ck("power_status_two", 1'h1, o_power_status_two);
    ck("power_status_one", 1'h1, o_power_status_one);
    i_tdm_data_in_pin <= 1'h1;
    fs_drv            <= 1'h1;
    i_tdm_clock_pin   <= 1'h1;
    i_tdm_tx_data     <= 1'h1;
    tick(2);
    ck("tdm_rx_data", 1'h1, o_tdm_rx_data);
    ck("frame_sync", 1'h1, o_frame_sync);
    ck("tdm_clock", 1'h1, o_tdm_clock);
    ck("tdm_dout", 1'h1, o_tdm_data_out_pin & o_tdm_data_out_pin_oe);
    w(A_CTRL, 8'hDE, RESP_OKAY);
    ck("adaptive_timing", 1'h0, o_adaptive_timing);
    w(A_AUX, 8'h01, RESP_OKAY);
    ck("power_status_two", 1'h0, o_power_status_two);
    ck("power_status_one", 1'h0, o_power_status_one);
    w(A_CTRL, 8'hFF, RESP_OKAY);
  endtask
  initial begin
    repeat (20000) @(posedge i_sys_clk);
    fail_count++;
    close_out();
  end
  initial begin
    i_sys_clk                 = 1'h0;
    i_nrst                    = 1'h0;
    i_act_mode_interrupt_pin  = 1'h0;
    i_received_activation_bit = 1'h0;
    i_u_rx_bd                 = 1'h1;
    i_st_rx_bd                = 1'h1;
    i_st_rx_d                 = 1'h0;
    fs_drv                    = 1'h0;
    p8_drv                    = 1'h0;
    i_tdm_data_in_pin         = 1'h0;
    i_tdm_clock_pin           = 1'h0;
    i_tdm_tx_data             = 1'h0;
    i_sync_loop_ind           = 1'h1;
    t_reset(1'h0);
    t_bits();
    t_loop();
    t_tdm();
    t_reset(1'h1);
    close_out();
  end
endmodule
bind st_global_control st_global_control_assertions u_chk (.*);
`default_nettype wire
